/* logic/spi_port_pkg.sv */
// constants and register map for the serial register access port
package spi_port_pkg;
    // register addresses
    localparam logic [6:0] ADDR_ID = 7'h00;
    localparam logic [6:0] ADDR_CFG_FIRST = 7'h01;
    localparam logic [6:0] ADDR_GUARD_LAST = 7'h05;
    localparam logic [6:0] ADDR_IRQ_SETUP = 7'h0a;
    localparam logic [6:0] ADDR_POWER = 7'h0b;
    localparam logic [6:0] ADDR_STATUS = 7'h20;
    localparam logic [6:0] ADDR_LOSS_LOW = 7'h21;
    localparam logic [6:0] ADDR_LOSS_HIGH = 7'h22;
    localparam logic [6:0] ADDR_FREQ_LOW = 7'h23;
    localparam logic [6:0] ADDR_FREQ_MID = 7'h24;
    localparam logic [6:0] ADDR_FREQ_HIGH = 7'h25;
    localparam int CFG_COUNT = 11;

    // field positions and values
    localparam int DIR_BIT = 7;
    localparam int POWER_ACTIVE_BIT = 0;
    localparam int STATUS_READY_BIT = 6;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam logic [2:0] IRQ_DRDY_MODE = 3'h4;

    // interrupt pulse width while a read is in progress
    localparam int REF_CLK_NS = 50;
    localparam int IRQ_PULSE_NS = 200;
    localparam int IRQ_PULSE_CYC_I = (IRQ_PULSE_NS + REF_CLK_NS - 1) / REF_CLK_NS;
    localparam logic [3:0] IRQ_PULSE_CYC = 4'(IRQ_PULSE_CYC_I);

    // reset values of the writable registers
    localparam logic [7:0] RST_RANGE_UPPER = 8'h0e;
    localparam logic [7:0] RST_RANGE_LOWER = 8'h14;
    localparam logic [7:0] RST_MIN_RES = 8'h45;
    localparam logic [7:0] RST_CONVERTER = 8'h1b;
    localparam logic [7:0] RST_TIMEBASE = 8'h01;
    localparam logic [7:0] RST_UPPER_LOW = 8'hff;
    localparam logic [7:0] RST_UPPER_HIGH = 8'hff;
    localparam logic [7:0] RST_LOWER_LOW = 8'h00;
    localparam logic [7:0] RST_LOWER_HIGH = 8'h00;
    localparam logic [7:0] RST_IRQ_SETUP = 8'h00;
    localparam logic [7:0] RST_POWER = 8'h00;

    // implemented bits; reserved bits hold zero
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_CONVERTER = 8'h1f;
    localparam logic [7:0] MASK_TIMEBASE = 8'h03;
    localparam logic [7:0] MASK_IRQ_SETUP = 8'h07;
    localparam logic [7:0] MASK_POWER = 8'h01;

    typedef enum logic [1:0] {st_idle, st_instr, st_data} link_state_t;

    function automatic logic [7:0] cfg_reset(input logic [6:0] addr);
        case (addr)
            7'h01: cfg_reset = RST_RANGE_UPPER;
            7'h02: cfg_reset = RST_RANGE_LOWER;
            7'h03: cfg_reset = RST_MIN_RES;
            7'h04: cfg_reset = RST_CONVERTER;
            7'h05: cfg_reset = RST_TIMEBASE;
            7'h06: cfg_reset = RST_UPPER_LOW;
            7'h07: cfg_reset = RST_UPPER_HIGH;
            7'h08: cfg_reset = RST_LOWER_LOW;
            7'h09: cfg_reset = RST_LOWER_HIGH;
            7'h0a: cfg_reset = RST_IRQ_SETUP;
            default: cfg_reset = RST_POWER;
        endcase
    endfunction

    function automatic logic [7:0] cfg_mask(input logic [6:0] addr);
        case (addr)
            7'h04: cfg_mask = MASK_CONVERTER;
            7'h05: cfg_mask = MASK_TIMEBASE;
            7'h0a: cfg_mask = MASK_IRQ_SETUP;
            7'h0b: cfg_mask = MASK_POWER;
            default: cfg_mask = MASK_FULL;
        endcase
    endfunction
endpackage

/* logic/sensor_spi_register_port.sv */
// serial register access port: spi slave, register file and data-ready pin
// Behaviour
// - slave only, never starts a transfer
// - 8-bit instruction: direction bit, 7-bit address
// - direction 0 writes, 1 reads
// - each chip-select assertion restarts decoding
// - output bit changes on falling clock
// - input bit captured on rising clock
// - single write commits at 16th rising edge
// - early release discards partial write
// - held select continues, address auto-increments
// - burst read shifts next register every 8
// - burst write stores each byte successively
// - burst from 0x21 returns loss, frequency
// - active mode blocks writes to 0x01-0x05
// - read-only identification register at 0x00
// - data-ready pin asserts, clears on 0x21 read
`timescale 1ns/1ps
module sensor_spi_register_port #(
    parameter logic [7:0] ID_CODE = 8'h5a // arbitrary value
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // spi link from the host
    input wire logic sclk_pin,
    input wire logic select_line_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    // measurement results
    input wire logic conversion_done,
    input wire logic [7:0] status_flags,
    input wire logic [15:0] loss_result,
    input wire logic [23:0] freq_count,
    // interrupt pin
    output logic irq_pin_n,
    // configuration towards the converter
    output logic [7:0] range_upper_code,
    output logic [7:0] range_lower_code,
    output logic [7:0] min_resonance_setting,
    output logic [7:0] converter_setup,
    output logic [7:0] timebase_setup,
    output logic [15:0] upper_trip,
    output logic [15:0] lower_trip,
    output logic [2:0] irq_pin_select,
    output logic active_mode_bit
);
    // synchronisers
    logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
    logic sel_s1_r, sel_s2_r;
    logic din_s1_r, din_s2_r;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_s3_r <= 1'b0;
            sel_s1_r <= 1'b1;
            sel_s2_r <= 1'b1;
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
        end
        else
        begin
            sclk_s1_r <= sclk_pin;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
            sel_s1_r <= select_line_n;
            sel_s2_r <= sel_s1_r;
            din_s1_r <= serial_in;
            din_s2_r <= din_s1_r;
        end
    end

    logic sclk_rise, sclk_fall, sel_active;
    assign sclk_rise = sclk_s2_r & ~sclk_s3_r;
    assign sclk_fall = ~sclk_s2_r & sclk_s3_r;
    assign sel_active = ~sel_s2_r;

    // register file and result shadow
    logic [7:0] cfg_r [1:spi_port_pkg::CFG_COUNT];
    logic [15:0] loss_r, loss_nxt;
    logic [23:0] freq_r, freq_nxt;
    logic pend_r, pend_nxt;
    logic data_ready_n_r, data_ready_n_nxt;

    function automatic logic [7:0] read_mux(input logic [6:0] addr);
        read_mux = 8'h00;
        if (addr == spi_port_pkg::ADDR_ID)
            read_mux = ID_CODE;
        else if (addr >= spi_port_pkg::ADDR_CFG_FIRST && addr <= spi_port_pkg::ADDR_POWER)
            read_mux = cfg_r[addr];
        else
        begin
            case (addr)
                spi_port_pkg::ADDR_STATUS:
                begin
                    read_mux = status_flags;
                    read_mux[spi_port_pkg::STATUS_READY_BIT] = data_ready_n_r;
                end
                spi_port_pkg::ADDR_LOSS_LOW: read_mux = loss_r[7:0];
                spi_port_pkg::ADDR_LOSS_HIGH: read_mux = loss_r[15:8];
                spi_port_pkg::ADDR_FREQ_LOW: read_mux = freq_r[7:0];
                spi_port_pkg::ADDR_FREQ_MID: read_mux = freq_r[15:8];
                spi_port_pkg::ADDR_FREQ_HIGH: read_mux = freq_r[23:16];
                default: read_mux = 8'h00;
            endcase
        end
    endfunction

    // link state
    spi_port_pkg::link_state_t state_r, state_nxt;
    logic [2:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] shift_in_r, shift_in_nxt;
    logic [7:0] shift_out_r, shift_out_nxt;
    logic [6:0] addr_r, addr_nxt;
    logic rw_r, rw_nxt;
    logic sout_r, sout_nxt;
    logic oe_r, oe_nxt;
    logic wr_en;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] byte_in;
    logic read_hit;
    logic hit_pend_r, hit_pend_nxt;

    always_comb
    begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_in_nxt = shift_in_r;
        shift_out_nxt = shift_out_r;
        addr_nxt = addr_r;
        rw_nxt = rw_r;
        sout_nxt = sout_r;
        oe_nxt = oe_r;
        wr_en = 1'b0;
        wr_addr = addr_r;
        wr_data = 8'h00;
        read_hit = 1'b0;
        hit_pend_nxt = hit_pend_r;
        byte_in = {shift_in_r[6:0], din_s2_r};
        if (!sel_active)
        begin
            // release mid-byte drops whatever was shifted so far
            state_nxt = spi_port_pkg::st_idle;
            bit_cnt_nxt = 3'h0;
            sout_nxt = 1'b0;
            oe_nxt = 1'b0;
            hit_pend_nxt = 1'b0;
        end
        else
        begin
            oe_nxt = 1'b1;
            if (state_r == spi_port_pkg::st_idle)
                state_nxt = spi_port_pkg::st_instr;
            if (sclk_rise)
            begin
                shift_in_nxt = byte_in;
                bit_cnt_nxt = bit_cnt_r + 3'h1;
                if (bit_cnt_r == spi_port_pkg::BYTE_LAST)
                begin
                    case (state_r)
                        spi_port_pkg::st_idle, spi_port_pkg::st_instr:
                        begin
                            rw_nxt = byte_in[spi_port_pkg::DIR_BIT];
                            addr_nxt = byte_in[6:0];
                            state_nxt = spi_port_pkg::st_data;
                            shift_out_nxt = read_mux(byte_in[6:0]);
                            read_hit = byte_in[spi_port_pkg::DIR_BIT]
                                & (byte_in[6:0] == spi_port_pkg::ADDR_LOSS_LOW);
                        end
                        spi_port_pkg::st_data:
                        begin
                            if (rw_r == spi_port_pkg::DIR_WRITE)
                            begin
                                wr_en = 1'b1;
                                wr_data = byte_in;
                            end
                            addr_nxt = addr_r + 7'h01;
                            shift_out_nxt = read_mux(addr_r + 7'h01);
                            // a status read that ends here must not count as a result read
                            hit_pend_nxt = rw_r
                                & ((addr_r + 7'h01) == spi_port_pkg::ADDR_LOSS_LOW);
                        end
                        default: state_nxt = spi_port_pkg::st_idle;
                    endcase
                end
            end
            else if (sclk_fall && state_r == spi_port_pkg::st_data && rw_r)
            begin
                sout_nxt = shift_out_r[7];
                shift_out_nxt = {shift_out_r[6:0], 1'b0};
                read_hit = hit_pend_r;
                hit_pend_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= spi_port_pkg::st_idle;
            bit_cnt_r <= 3'h0;
            shift_in_r <= 8'h00;
            shift_out_r <= 8'h00;
            addr_r <= 7'h00;
            rw_r <= 1'b0;
            sout_r <= 1'b0;
            oe_r <= 1'b0;
            hit_pend_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_in_r <= shift_in_nxt;
            shift_out_r <= shift_out_nxt;
            addr_r <= addr_nxt;
            rw_r <= rw_nxt;
            sout_r <= sout_nxt;
            oe_r <= oe_nxt;
            hit_pend_r <= hit_pend_nxt;
        end
    end

    // configuration registers
    logic [7:0] cfg_nxt [1:spi_port_pkg::CFG_COUNT];
    logic guarded;
    assign guarded = cfg_r[spi_port_pkg::ADDR_POWER][spi_port_pkg::POWER_ACTIVE_BIT]
        && wr_addr <= spi_port_pkg::ADDR_GUARD_LAST;

    always_comb
    begin
        for (int i = 1; i <= spi_port_pkg::CFG_COUNT; i++)
            cfg_nxt[i] = cfg_r[i];
        if (wr_en && wr_addr >= spi_port_pkg::ADDR_CFG_FIRST
            && wr_addr <= spi_port_pkg::ADDR_POWER && !guarded)
            cfg_nxt[wr_addr] = wr_data & spi_port_pkg::cfg_mask(wr_addr);
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 1; i <= spi_port_pkg::CFG_COUNT; i++)
                cfg_r[i] <= spi_port_pkg::cfg_reset(7'(i));
        end
        else
        begin
            for (int i = 1; i <= spi_port_pkg::CFG_COUNT; i++)
                cfg_r[i] <= cfg_nxt[i];
        end
    end

    // result shadow, frozen while the link is busy so a burst reads one set
    logic drdy_mode, read_busy;
    logic [3:0] pulse_r, pulse_nxt;
    logic irq_n_r, irq_n_nxt;
    assign drdy_mode = cfg_r[spi_port_pkg::ADDR_IRQ_SETUP][2:0] == spi_port_pkg::IRQ_DRDY_MODE;
    assign read_busy = state_r == spi_port_pkg::st_data && rw_r;

    always_comb
    begin
        loss_nxt = loss_r;
        freq_nxt = freq_r;
        pend_nxt = pend_r | conversion_done;
        if (!sel_active && pend_nxt)
        begin
            loss_nxt = loss_result;
            freq_nxt = freq_count;
            pend_nxt = 1'b0;
        end
        data_ready_n_nxt = data_ready_n_r;
        pulse_nxt = pulse_r;
        if (pulse_r != 4'h0)
            pulse_nxt = pulse_r - 4'h1;
        if (read_hit)
            data_ready_n_nxt = 1'b1;
        if (conversion_done)
        begin
            if (read_busy)
                pulse_nxt = spi_port_pkg::IRQ_PULSE_CYC;
            else
                data_ready_n_nxt = 1'b0;
        end
        irq_n_nxt = drdy_mode ? (data_ready_n_nxt & (pulse_nxt == 4'h0)) : 1'b1;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            loss_r <= 16'h0000;
            freq_r <= 24'h00_0000;
            pend_r <= 1'b0;
            data_ready_n_r <= 1'b1;
            pulse_r <= 4'h0;
            irq_n_r <= 1'b1;
        end
        else
        begin
            loss_r <= loss_nxt;
            freq_r <= freq_nxt;
            pend_r <= pend_nxt;
            data_ready_n_r <= data_ready_n_nxt;
            pulse_r <= pulse_nxt;
            irq_n_r <= irq_n_nxt;
        end
    end

    // outputs, all straight from flip-flops
    assign serial_out = sout_r;
    assign serial_out_oe = oe_r;
    assign irq_pin_n = irq_n_r;
    assign range_upper_code = cfg_r[1];
    assign range_lower_code = cfg_r[2];
    assign min_resonance_setting = cfg_r[3];
    assign converter_setup = cfg_r[4];
    assign timebase_setup = cfg_r[5];
    assign upper_trip = {cfg_r[7], cfg_r[6]};
    assign lower_trip = {cfg_r[9], cfg_r[8]};
    assign irq_pin_select = cfg_r[spi_port_pkg::ADDR_IRQ_SETUP][2:0];
    assign active_mode_bit = cfg_r[spi_port_pkg::ADDR_POWER][spi_port_pkg::POWER_ACTIVE_BIT];
endmodule

/* verif/spi_port_sva.sv */
// assertions and covers for the serial register access port
`timescale 1ns/1ps
module spi_port_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // serial link
    input wire logic sclk_pin,
    input wire logic select_line_n,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    // results and interrupt
    input wire logic conversion_done,
    input wire logic irq_pin_n,
    // configuration
    input wire logic [7:0] range_upper_code,
    input wire logic [7:0] range_lower_code,
    input wire logic [7:0] min_resonance_setting,
    input wire logic [7:0] converter_setup,
    input wire logic [7:0] timebase_setup,
    input wire logic [15:0] upper_trip,
    input wire logic [15:0] lower_trip,
    input wire logic [2:0] irq_pin_select,
    input wire logic active_mode_bit
);
    logic sclk_r;
    logic sclk_nxt;
    logic [3:0] age_r;
    logic [3:0] age_nxt;
    logic [39:0] guard;
    logic [75:0] cfg;
    logic drdy;

    assign guard = {range_upper_code, range_lower_code, min_resonance_setting,
        converter_setup, timebase_setup};
    assign cfg = {guard, upper_trip, lower_trip, irq_pin_select, active_mode_bit};
    assign drdy = irq_pin_select == spi_port_pkg::IRQ_DRDY_MODE;

    // cycles since the link clock last fell
    always_comb
    begin
        sclk_nxt = sclk_pin;
        age_nxt = (age_r == 4'hf) ? age_r : age_r + 4'h1;
        if (sclk_r && !sclk_pin)
            age_nxt = 4'h0;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sclk_r <= 1'b1;
            age_r <= 4'hf;
        end
        else
        begin
            sclk_r <= sclk_nxt;
            age_r <= age_nxt;
        end
    end

    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    a_oe_on_select: assert property (!select_line_n [*5] |-> serial_out_oe)
        else $error("output enable low while selected");
    a_oe_off_idle: assert property (select_line_n [*5] |-> !serial_out_oe)
        else $error("output driven while deselected");
    a_out_on_fall: assert property (serial_out_oe && $past(serial_out_oe, 2)
        && $changed(serial_out) |-> age_r <= 4'h5)
        else $error("serial output moved away from a falling edge");
    a_cfg_in_frame: assert property (!$stable(cfg) |-> !$past(select_line_n, 3))
        else $error("configuration changed outside a frame");
    a_guard_lock: assert property (active_mode_bit && $past(active_mode_bit)
        |-> $stable(guard))
        else $error("guarded register changed in active mode");
    a_irq_off_mode: assert property (!drdy && !$past(drdy) |-> irq_pin_n)
        else $error("interrupt pin low outside data-ready mode");
    a_irq_on_done: assert property (drdy && conversion_done && select_line_n
        && $past(select_line_n, 10) |-> ##[1:3] !irq_pin_n)
        else $error("interrupt pin not raised after conversion");
    a_irq_holds: assert property (drdy && !irq_pin_n && select_line_n
        && $past(select_line_n, 10) |=> !irq_pin_n)
        else $error("interrupt pin released while idle");

    c_read_bit: cover property (serial_out_oe && $rose(serial_out));
    c_guard_write: cover property (!$stable(guard));
    c_irq_raise: cover property ($fell(irq_pin_n));
    c_irq_pulse: cover property (!select_line_n && $fell(irq_pin_n));
endmodule

bind sensor_spi_register_port spi_port_sva chk (
    .ref_clk(ref_clk), .nrst(nrst), .sclk_pin(sclk_pin), .select_line_n(select_line_n),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .conversion_done(conversion_done), .irq_pin_n(irq_pin_n),
    .range_upper_code(range_upper_code), .range_lower_code(range_lower_code),
    .min_resonance_setting(min_resonance_setting), .converter_setup(converter_setup),
    .timebase_setup(timebase_setup), .upper_trip(upper_trip), .lower_trip(lower_trip),
    .irq_pin_select(irq_pin_select), .active_mode_bit(active_mode_bit));

/* verif/spi_host_model.sv */
// host master model driving the serial link
`timescale 1ns/1ps
module spi_host_model (
    // clock
    input wire logic ref_clk,
    // link towards the device
    output logic sclk_pin,
    output logic select_line_n,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    // half link period of 200 ns
    localparam int HALF = 4;
    logic last_r = 1'b0;

    initial
    begin
        sclk_pin = 1'b1;
        select_line_n = 1'b1;
        serial_in = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // one frame of nbits clocks; tx leaves msb first, rx gathers the returned stream
    task automatic frame(input int nbits, input logic [47:0] tx, output logic [47:0] rx);
        rx = '0;
        select_line_n = 1'b0;
        wait_n(HALF);
        for (int i = 0; i < nbits; i++)
        begin
            sclk_pin = 1'b0;
            serial_in = tx[47 - i];
            wait_n(HALF);
            // a released output reads as the inverse of its last level
            last_r = serial_out_oe ? serial_out : ~last_r;
            rx = {rx[46:0], last_r};
            sclk_pin = 1'b1;
            wait_n(HALF);
        end
        select_line_n = 1'b1;
        serial_in = ~serial_in;
        wait_n(2 * HALF);
    endtask
endmodule

/* verif/sensor_spi_register_port_tb.sv */
// self-checking bench for the serial register access port
`timescale 1ns/1ps
module sensor_spi_register_port_tb;
    localparam logic [7:0] ID = 8'ha6; // arbitrary identification value
    logic ref_clk, nrst, sclk_pin, select_line_n, serial_in, serial_out, serial_out_oe;
    logic conversion_done, irq_pin_n, active_mode_bit;
    logic [7:0] status_flags, range_upper_code, range_lower_code, min_resonance_setting;
    logic [7:0] converter_setup, timebase_setup;
    logic [15:0] loss_result, upper_trip, lower_trip;
    logic [23:0] freq_count;
    logic [2:0] irq_pin_select;
    logic [39:0] q;
    logic [47:0] junk;
    logic [7:0] rst_tab [12] = '{ID, 8'h0e, 8'h14, 8'h45, 8'h1b, 8'h01, 8'hff, 8'hff,
        8'h00, 8'h00, 8'h00, 8'h00};
    int fail_count = 0;
    int check_count = 0;

    sensor_spi_register_port #(.ID_CODE(ID)) dut (
        .ref_clk(ref_clk), .nrst(nrst), .sclk_pin(sclk_pin), .select_line_n(select_line_n),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .conversion_done(conversion_done), .status_flags(status_flags),
        .loss_result(loss_result), .freq_count(freq_count), .irq_pin_n(irq_pin_n),
        .range_upper_code(range_upper_code), .range_lower_code(range_lower_code),
        .min_resonance_setting(min_resonance_setting), .converter_setup(converter_setup),
        .timebase_setup(timebase_setup), .upper_trip(upper_trip), .lower_trip(lower_trip),
        .irq_pin_select(irq_pin_select), .active_mode_bit(active_mode_bit));

    spi_host_model host (
        .ref_clk(ref_clk), .sclk_pin(sclk_pin), .select_line_n(select_line_n),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input int n, input logic [39:0] d);
        logic [47:0] rx;
        host.frame(8 + 8 * n, {1'b0, a, d}, rx);
    endtask

    task automatic rd(input logic [6:0] a, input int n, output logic [39:0] d);
        logic [47:0] rx;
        host.frame(8 + 8 * n, {1'b1, a, 40'h0}, rx);
        d = rx[39:0] & ~({40{1'b1}} << (8 * n));
    endtask

    task automatic pulse();
        repeat (4) @(negedge ref_clk);
        conversion_done = 1'b1;
        @(negedge ref_clk);
        conversion_done = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #2_000_000;
        fail_count++;
        stop_test();
    end

    initial
    begin
        nrst = 1'b0;
        conversion_done = 1'b0;
        status_flags = 8'hc3;
        loss_result = 16'h1234;
        freq_count = 24'hab_cdef;
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk(40'({upper_trip, lower_trip, irq_pin_select, active_mode_bit, irq_pin_n}),
            40'h1f_ffe0_0001);
        chk(40'({range_upper_code, range_lower_code, min_resonance_setting,
            converter_setup, timebase_setup}), 40'h0e14_451b_01);
        for (int i = 0; i < 12; i++)
        begin
            rd(7'(i), 1, q);
            chk(q, 40'(rst_tab[i]));
        end
        wr(7'h03, 1, 40'h55_0000_0000);
        chk(40'(min_resonance_setting), 40'h55);
        rd(7'h03, 1, q);
        chk(q, 40'h55);
        wr(7'h00, 1, 40'h33_0000_0000);
        rd(7'h00, 1, q);
        chk(q, 40'(ID));
        host.frame(15, {1'b0, 7'h02, 8'h99, 32'h0}, junk);
        rd(7'h02, 1, q);
        chk(q, 40'h14);
        wr(7'h06, 4, 40'ha1_b2c3_d400);
        chk(40'({upper_trip, lower_trip}), 40'hb2a1_d4c3);
        rd(7'h06, 4, q);
        chk(q, 40'ha1b2_c3d4);
        wr(7'h04, 1, 40'h0c_0000_0000);
        chk(40'(converter_setup), 40'h0c);
        rd(7'h30, 1, q);
        chk(q, 40'h0);
        wr(7'h0b, 1, 40'h01_0000_0000);
        wr(7'h01, 2, 40'h9988_0000_00);
        wr(7'h07, 1, 40'h12_0000_0000);
        wr(7'h05, 1, 40'h02_0000_0000);
        chk(40'({active_mode_bit, range_upper_code, range_lower_code, upper_trip}),
            40'h1_0e14_12a1);
        chk(40'(timebase_setup), 40'h01);
        wr(7'h0b, 1, 40'h0);
        wr(7'h01, 1, 40'h99_0000_0000);
        chk(40'(range_upper_code), 40'h99);
        pulse();
        chk(40'(irq_pin_n), 40'h1);
        wr(7'h0a, 1, 40'h04_0000_0000);
        pulse();
        chk(40'({irq_pin_select, irq_pin_n}), 40'h8);
        rd(7'h20, 1, q);
        chk(q, 40'h83);
        chk(40'(irq_pin_n), 40'h0);
        rd(7'h21, 5, q);
        chk(q, 40'h34_12ef_cdab);
        chk(40'(irq_pin_n), 40'h1);
        // conversion during a read only pulses the pin
        fork
            rd(7'h20, 2, q);
            begin
                repeat (96) @(negedge ref_clk);
                pulse();
            end
        join
        chk(q, 40'hc334);
        chk(40'(irq_pin_n), 40'h1);
        rd(7'h20, 1, q);
        chk(q, 40'hc3);
        stop_test();
    end
endmodule
